// *** hdl/digitizer_pkg.sv ***
// constants, types and window table shared by the digitizer acquisition block
// Overview of operation
// - sample spacing never shorter than a 50 kHz rate; faster settings are limited
// - interval rounds to the nearest whole 20.48 us base period, used as spacing
// - negative offset keeps pre-trigger samples at the head of the buffer
// - zero offset stores every sample after the trigger, first one at the trigger
// - positive offset waits offset times the sample period before storing
// - triggers before the pre-trigger count is collected are ignored, not held; stays armed
// - rectangular window at power-on; window select can switch to Hanning
// - rectangular window gives a plain unweighted mean of the buffer
// - Hanning window weights samples by a sine-to-the-fourth shape before averaging
// - array readout returns stored samples raw, no averaging or windowing
// - measure request initiates, triggers itself and returns the array when done
// - fetch returns the last acquisition without a new one, buffer unchanged
// - fetch before an acquisition completes is held until capture completes
// - dual-converter unit captures voltage and current together every time
// - trigger taken from one selected source: bus, transient or external pin
// - trigger system idle at power-up, ignores triggers, returns idle after capture
// - abort forces the initiated trigger system back to idle
package digitizer_pkg;
    localparam int DEPTH = 64;
    localparam int IDX_W = 6;
    localparam int CNT_W = 7;
    localparam int SAMPLE_W = 16;
    localparam int INTERVAL_W = 24;
    localparam int UNIT_W = 8;
    localparam int PERIOD_W = 19;
    localparam int WEIGHT_W = 8;
    localparam int ACC_W = 30;
    localparam int WSUM_W = 14;
    localparam int CLK_PERIOD_NS = 10;
    localparam real BASE_PERIOD_US = 20.48;
    localparam int BASE_CYCLES = int'(BASE_PERIOD_US * 1000.0 / CLK_PERIOD_NS);
    localparam int MAX_RATE_HZ = 50000;
    localparam int MIN_INTERVAL_CYCLES =
        (1000000000 / CLK_PERIOD_NS + MAX_RATE_HZ - 1) / MAX_RATE_HZ;
    localparam int MIN_UNITS = (MIN_INTERVAL_CYCLES + BASE_CYCLES - 1) / BASE_CYCLES;
    localparam int MAX_UNITS = 255;
    localparam logic [INTERVAL_W:0] BASE_DIV = 25'(BASE_CYCLES);
    localparam logic [INTERVAL_W:0] HALF_BASE = 25'(BASE_CYCLES / 2);
    localparam logic [CNT_W-1:0] MIN_COUNT = 7'h01;
    localparam logic [CNT_W-1:0] MAX_COUNT = 7'h40;
    localparam logic [WEIGHT_W-1:0] FULL_WEIGHT = 8'hFF;
    typedef enum logic [1:0] {SRC_BUS, SRC_TRANSIENT, SRC_PIN} trig_src_t;
    typedef enum logic {QTY_VOLTAGE, QTY_CURRENT} quantity_t;
    typedef enum logic {WIN_RECTANGULAR, WIN_HANNING} window_t;
    // sin^4 over half a period, index 0..32 of a 64-step period
    localparam logic [WEIGHT_W-1:0] HANN_LUT [0:32] = '{
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h09, 8'h0D,
        8'h12, 8'h18, 8'h20, 8'h29, 8'h34, 8'h40, 8'h4D, 8'h5B, 8'h6A, 8'h7A, 8'h8A,
        8'h9A, 8'hAA, 8'hBA, 8'hC8, 8'hD6, 8'hE2, 8'hEC, 8'hF4, 8'hFA, 8'hFE, 8'hFF};
endpackage

// *** hdl/triggered_digitizer_acquisition.sv ***
// triggered digitizer acquisition: sampling, trigger system, buffer, readout, averages
`timescale 1ns/10ps
`default_nettype none
module triggered_digitizer_acquisition (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // acquisition settings
    input wire logic [digitizer_pkg::INTERVAL_W-1:0] sample_interval_setting,
    input wire logic [digitizer_pkg::CNT_W-1:0] sample_count_setting,
    input wire logic signed [7:0] trigger_offset_points,
    input wire digitizer_pkg::window_t window_select,
    input wire digitizer_pkg::quantity_t measured_quantity_select,
    input wire logic dual_converter,
    input wire digitizer_pkg::trig_src_t trigger_source_select,
    // trigger system
    input wire logic initiate_request,
    input wire logic abort_request,
    input wire logic bus_trigger,
    input wire logic transient_trigger,
    input wire logic pin_trigger,
    // array requests
    input wire logic measure_voltage_array_request,
    input wire logic measure_current_array_request,
    input wire logic fetch_voltage_array_request,
    input wire logic fetch_current_array_request,
    // converters
    input wire logic [digitizer_pkg::SAMPLE_W-1:0] voltage_sample,
    input wire logic [digitizer_pkg::SAMPLE_W-1:0] current_sample,
    // array response
    output logic array_valid,
    output logic [digitizer_pkg::SAMPLE_W-1:0] array_data,
    output logic array_last,
    input wire logic array_ready,
    // status and averages
    output logic trigger_idle,
    output logic acquisition_done,
    output logic [digitizer_pkg::UNIT_W-1:0] actual_interval_units,
    output logic [digitizer_pkg::SAMPLE_W-1:0] voltage_average,
    output logic [digitizer_pkg::SAMPLE_W-1:0] current_average
);
    import digitizer_pkg::*;

    typedef enum logic [2:0] {ST_IDLE, ST_ARMED, ST_DELAY, ST_CAPTURE, ST_AVERAGE} state_t;

    typedef struct packed {
        state_t state;
        logic [UNIT_W-1:0] units;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] pre;
        logic [CNT_W-1:0] skip;
        logic [CNT_W-1:0] stored;
        logic [CNT_W-1:0] pre_seen;
        logic [CNT_W-1:0] avg_k;
        logic [CNT_W-1:0] ro_idx;
        quantity_t qty;
        window_t window;
        logic dual;
        logic self_trig;
        logic data_valid;
        logic pend;
        quantity_t pend_qty;
        quantity_t ro_qty;
        logic ro_valid;
        logic ro_last;
        logic [PERIOD_W-1:0] tick_cnt;
        logic [IDX_W-1:0] wr;
        logic [IDX_W-1:0] start;
        logic [SAMPLE_W-1:0] ro_data;
        logic [DEPTH-1:0][SAMPLE_W-1:0] volt_mem;
        logic [DEPTH-1:0][SAMPLE_W-1:0] curr_mem;
    } acq_state_t;

    acq_state_t s;
    acq_state_t d;
    logic [INTERVAL_W:0] quo;
    logic [UNIT_W-1:0] units_in;
    logic [CNT_W-1:0] count_in;
    logic [8:0] neg_off;
    logic [CNT_W-1:0] pre_in;
    logic [PERIOD_W-1:0] period_m1;
    logic tick;
    logic src_trig;
    logic trig_in;
    logic start_req;
    logic measure_any;
    logic store;
    logic finish;
    logic ro_start;
    logic [IDX_W-1:0] rd_pos;
    logic [IDX_W-1:0] av_pos;
    logic av_valid;
    logic av_finish;

    // interval rounded to nearest base period, clamped to the rate limit
    assign quo = ({1'b0, sample_interval_setting} + HALF_BASE) / BASE_DIV;
    assign units_in = (quo < 25'(MIN_UNITS)) ? UNIT_W'(MIN_UNITS) :
        (quo > 25'(MAX_UNITS)) ? UNIT_W'(MAX_UNITS) : quo[UNIT_W-1:0];
    assign count_in = (sample_count_setting < MIN_COUNT) ? MIN_COUNT :
        (sample_count_setting > MAX_COUNT) ? MAX_COUNT : sample_count_setting;
    assign neg_off = ~{trigger_offset_points[7], trigger_offset_points} + 9'h001;
    // pre-trigger depth never exceeds the buffer, which is the circular store
    assign pre_in = !trigger_offset_points[7] ? '0 :
        (neg_off > {2'b00, count_in}) ? count_in : neg_off[CNT_W-1:0];
    assign period_m1 = PERIOD_W'(int'(s.units) * BASE_CYCLES - 1);
    assign tick = (s.tick_cnt == '0);
    assign measure_any = measure_voltage_array_request | measure_current_array_request;
    assign start_req = (initiate_request | measure_any) && s.state == ST_IDLE && !s.ro_valid;
    assign ro_start = s.pend && s.data_valid && s.state == ST_IDLE && !s.ro_valid;
    assign rd_pos = s.start + (ro_start ? '0 : s.ro_idx[IDX_W-1:0]);
    assign av_pos = s.start + s.avg_k[IDX_W-1:0];
    assign av_valid = s.state == ST_AVERAGE && s.avg_k != s.count;
    assign av_finish = s.state == ST_AVERAGE && s.avg_k == s.count;

    always_comb begin
        case (trigger_source_select)
            SRC_BUS: src_trig = bus_trigger;
            SRC_TRANSIENT: src_trig = transient_trigger;
            SRC_PIN: src_trig = pin_trigger;
            default: src_trig = 1'b0;
        endcase
        trig_in = src_trig | s.self_trig;
    end

    always_comb begin
        d = s;
        store = 1'b0;
        finish = 1'b0;
        d.tick_cnt = tick ? period_m1 : s.tick_cnt - 1'b1;
        case (s.state)
            ST_IDLE: begin
                // triggers fall through unused here
                if (start_req) begin
                    d.state = ST_ARMED;
                    d.units = units_in;
                    d.count = count_in;
                    d.pre = pre_in;
                    d.skip = trigger_offset_points[7] ? '0 : trigger_offset_points[6:0];
                    d.qty = measured_quantity_select;
                    d.window = window_select;
                    d.dual = dual_converter;
                    d.self_trig = measure_any;
                    d.wr = '0;
                    d.pre_seen = '0;
                    d.data_valid = 1'b0;
                end
            end
            ST_ARMED: begin
                if (tick && s.pre != '0) begin
                    store = 1'b1;
                    if (s.pre_seen != s.pre) d.pre_seen = s.pre_seen + 1'b1;
                end
                if (trig_in && s.pre_seen >= s.pre) begin
                    if (s.pre != '0) begin
                        d.stored = s.pre;
                        d.state = ST_CAPTURE;
                        finish = (s.pre == s.count);
                    end else if (s.skip == '0) begin
                        store = 1'b1;
                        d.stored = 7'h01;
                        d.tick_cnt = period_m1;
                        d.state = ST_CAPTURE;
                        finish = (s.count == 7'h01);
                    end else begin
                        d.tick_cnt = period_m1;
                        d.state = ST_DELAY;
                    end
                end
            end
            ST_DELAY: begin
                if (tick) begin
                    d.skip = s.skip - 1'b1;
                    if (s.skip == 7'h01) begin
                        store = 1'b1;
                        d.stored = 7'h01;
                        d.state = ST_CAPTURE;
                        finish = (s.count == 7'h01);
                    end
                end
            end
            ST_CAPTURE: begin
                if (tick) begin
                    store = 1'b1;
                    d.stored = s.stored + 1'b1;
                    finish = (s.stored + 1'b1 == s.count);
                end
            end
            ST_AVERAGE: begin
                if (av_finish) begin
                    d.state = ST_IDLE;
                    d.data_valid = 1'b1;
                    d.self_trig = 1'b0;
                end else begin
                    d.avg_k = s.avg_k + 1'b1;
                end
            end
            default: d.state = ST_IDLE;
        endcase
        if (store) begin
            // a single converter keeps only the chosen quantity
            d.volt_mem[s.wr] = (s.dual || s.qty == QTY_VOLTAGE) ? voltage_sample : '0;
            d.curr_mem[s.wr] = (s.dual || s.qty == QTY_CURRENT) ? current_sample : '0;
            d.wr = s.wr + 1'b1;
        end
        if (finish) begin
            d.start = d.wr - s.count[IDX_W-1:0];
            d.avg_k = '0;
            d.state = ST_AVERAGE;
        end
        if (abort_request && (s.state == ST_ARMED || s.state == ST_DELAY ||
            s.state == ST_CAPTURE)) begin
            d.state = ST_IDLE;
            d.self_trig = 1'b0;
            d.pend = 1'b0;
        end
        if (ro_start) begin
            d.pend = 1'b0;
            d.ro_valid = 1'b1;
            d.ro_qty = s.pend_qty;
            d.ro_idx = 7'h01;
            d.ro_last = (s.count == 7'h01);
            d.ro_data = (s.pend_qty == QTY_VOLTAGE) ? s.volt_mem[rd_pos] : s.curr_mem[rd_pos];
        end else if (s.ro_valid && array_ready) begin
            if (s.ro_last) begin
                d.ro_valid = 1'b0;
                d.ro_last = 1'b0;
            end else begin
                // raw stored word, no conditioning
                d.ro_data = (s.ro_qty == QTY_VOLTAGE) ? s.volt_mem[rd_pos] :
                    s.curr_mem[rd_pos];
                d.ro_idx = s.ro_idx + 1'b1;
                d.ro_last = (s.ro_idx + 1'b1 == s.count);
            end
        end
        if (start_req && measure_any) begin
            d.pend = 1'b1;
            d.pend_qty = measure_current_array_request ? QTY_CURRENT : QTY_VOLTAGE;
        end else if (fetch_voltage_array_request || fetch_current_array_request) begin
            d.pend = 1'b1;
            d.pend_qty = fetch_current_array_request ? QTY_CURRENT : QTY_VOLTAGE;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= d;
        end
    end

    window_averager volt_avg (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .sample_valid(av_valid),
        .first_sample(s.avg_k == '0),
        .position(s.avg_k[IDX_W-1:0]),
        .count(s.count),
        .window(s.window),
        .sample(s.volt_mem[av_pos]),
        .finish(av_finish),
        .average(voltage_average)
    );

    window_averager curr_avg (
        .ref_clk(ref_clk),
        .arst_n(arst_n),
        .sample_valid(av_valid),
        .first_sample(s.avg_k == '0),
        .position(s.avg_k[IDX_W-1:0]),
        .count(s.count),
        .window(s.window),
        .sample(s.curr_mem[av_pos]),
        .finish(av_finish),
        .average(current_average)
    );

    assign array_valid = s.ro_valid;
    assign array_data = s.ro_data;
    assign array_last = s.ro_last;
    assign trigger_idle = (s.state == ST_IDLE);
    assign acquisition_done = s.data_valid;
    assign actual_interval_units = s.units;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    rate_gap_a: assert property (tick |=> !tick [*8])
        else $error("sample ticks closer than the rate limit");
    interval_round_a: assert property (start_req && quo >= 25'(MIN_UNITS) &&
        quo <= 25'(MAX_UNITS) |=> int'(s.units) * BASE_CYCLES + BASE_CYCLES / 2 >=
        int'($past(sample_interval_setting)) && int'(s.units) * BASE_CYCLES <=
        int'($past(sample_interval_setting)) + BASE_CYCLES / 2)
        else $error("interval not rounded to nearest base period");
    idle_ignore_a: assert property (s.state == ST_IDLE && !start_req |=>
        s.state == ST_IDLE)
        else $error("trigger system left idle without initiate");
    pre_ignore_a: assert property (s.state == ST_ARMED && s.pre_seen < s.pre &&
        !abort_request |=> s.state == ST_ARMED)
        else $error("trigger accepted before pre-trigger count");
    zero_align_a: assert property (s.state == ST_ARMED && trig_in && s.pre == '0 &&
        s.skip == '0 && s.count > 7'h01 && !abort_request |=> s.state == ST_CAPTURE &&
        s.stored == 7'h01 && s.wr == $past(s.wr) + 1'b1)
        else $error("zero offset first sample not at trigger");
    delay_enter_a: assert property (s.state == ST_ARMED && trig_in && s.pre == '0 &&
        s.skip != '0 && !abort_request |=> s.state == ST_DELAY && s.tick_cnt == period_m1)
        else $error("positive offset did not start delay");
    abort_idle_a: assert property (abort_request && s.state inside {ST_ARMED, ST_DELAY,
        ST_CAPTURE} |=> s.state == ST_IDLE && !s.self_trig)
        else $error("abort did not return to idle");
    fetch_hold_a: assert property (s.ro_valid |-> s.data_valid && s.state == ST_IDLE)
        else $error("array returned before capture completed");
    buffer_stable_a: assert property (s.ro_valid |=> $stable(s.volt_mem) &&
        $stable(s.curr_mem))
        else $error("buffer changed during readout");
    dual_capture_a: assert property (store && s.dual && !abort_request |=>
        s.volt_mem[$past(s.wr)] == $past(voltage_sample) &&
        s.curr_mem[$past(s.wr)] == $past(current_sample))
        else $error("dual converter did not store both quantities");
endmodule
`default_nettype wire

// *** hdl/window_averager.sv ***
// weighted mean of one buffered quantity, rectangular or Hanning
`timescale 1ns/10ps
`default_nettype none
module window_averager (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // sample walk
    input wire logic sample_valid,
    input wire logic first_sample,
    input wire logic [digitizer_pkg::IDX_W-1:0] position,
    input wire logic [digitizer_pkg::CNT_W-1:0] count,
    input wire digitizer_pkg::window_t window,
    input wire logic [digitizer_pkg::SAMPLE_W-1:0] sample,
    input wire logic finish,
    // result
    output logic [digitizer_pkg::SAMPLE_W-1:0] average
);
    import digitizer_pkg::*;

    typedef struct packed {
        logic [ACC_W-1:0] acc;
        logic [WSUM_W-1:0] wsum;
        logic [SAMPLE_W-1:0] avg;
    } avg_state_t;

    avg_state_t s;
    avg_state_t d;
    logic [11:0] phase;
    logic [5:0] lut_idx;
    logic [WEIGHT_W-1:0] weight;
    logic [23:0] prod;

    always_comb begin
        phase = {position, 6'h00} / {5'h00, count};
        lut_idx = phase[5] ? 6'(7'h40 - {1'b0, phase[5:0]}) : phase[5:0];
        weight = (window == WIN_HANNING) ? HANN_LUT[lut_idx] : FULL_WEIGHT;
        prod = sample * weight;
        d = s;
        if (sample_valid) begin
            d.acc = (first_sample ? '0 : s.acc) + {6'h00, prod};
            d.wsum = (first_sample ? '0 : s.wsum) + {6'h00, weight};
        end
        if (finish) begin
            d.avg = (s.wsum == '0) ? '0 : SAMPLE_W'(s.acc / {16'h0000, s.wsum});
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s <= '0;
        end else begin
            s <= d;
        end
    end

    assign average = s.avg;

    hann_edge_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sample_valid && window == WIN_HANNING && position == '0 |-> weight == '0)
        else $error("hanning weight not zero at window edge");
    rect_sum_a: assert property (@(posedge ref_clk) disable iff (!arst_n)
        sample_valid && first_sample && window == WIN_RECTANGULAR
        |=> s.wsum == 14'(FULL_WEIGHT))
        else $error("rectangular weight sum wrong");
endmodule
`default_nettype wire

// *** tb/converter_model.sv ***
// converter stand-in: voltage and current words that change every clock
`timescale 1ns/10ps
`default_nettype none
module converter_model (
    // clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // converter words
    output logic [digitizer_pkg::SAMPLE_W-1:0] voltage_sample,
    output logic [digitizer_pkg::SAMPLE_W-1:0] current_sample
);
    import digitizer_pkg::*;
    logic [SAMPLE_W-1:0] tick_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_q <= 16'h0000;
        end else begin
            tick_q <= tick_q + 16'h0001;
        end
    end
    // one running count feeds both, so the store cycle and pairing show in the data
    assign voltage_sample = tick_q;
    assign current_sample = ~tick_q;
endmodule
`default_nettype wire

// *** tb/triggered_digitizer_acquisition_bench.sv ***
// self-checking bench for the triggered digitizer acquisition block
`timescale 1ns/10ps
`default_nettype none
`define CHECK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("BAD %s exp %0h got %0h", nm, e, g); end end
module triggered_digitizer_acquisition_bench;
    import digitizer_pkg::*;
    localparam int P = 2048;
    logic ref_clk, arst_n, dual, init_req, abort_req, bus_trg, tran_trg, pin_trg, a_ready;
    logic mv_req, mc_req, fv_req, fc_req, a_valid, a_last, t_idle, done;
    logic [INTERVAL_W-1:0] interval;
    logic [CNT_W-1:0] count;
    logic signed [7:0] offset;
    window_t win;
    quantity_t qty;
    trig_src_t src;
    logic [SAMPLE_W-1:0] v_smp, c_smp, a_data, v_avg, c_avg, trig_word, fl;
    logic [UNIT_W-1:0] units;
    logic [SAMPLE_W-1:0] got [$];
    logic [INTERVAL_W-1:0] ivals [5] = '{24'h000064, 24'h001800, 24'h001388, 24'h001450,
        24'hFFFFFF};
    logic [UNIT_W-1:0] uexp [5] = '{8'h01, 8'h03, 8'h02, 8'h03, 8'hFF};
    int err_total, cmp_count;
    converter_model conv_u (.ref_clk(ref_clk), .arst_n(arst_n), .voltage_sample(v_smp),
        .current_sample(c_smp));
    triggered_digitizer_acquisition dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .sample_interval_setting(interval),
        .sample_count_setting(count), .trigger_offset_points(offset), .window_select(win),
        .measured_quantity_select(qty), .dual_converter(dual), .trigger_source_select(src),
        .initiate_request(init_req), .abort_request(abort_req), .bus_trigger(bus_trg),
        .transient_trigger(tran_trg), .pin_trigger(pin_trg),
        .measure_voltage_array_request(mv_req), .measure_current_array_request(mc_req),
        .fetch_voltage_array_request(fv_req), .fetch_current_array_request(fc_req),
        .voltage_sample(v_smp), .current_sample(c_smp), .array_valid(a_valid),
        .array_data(a_data), .array_last(a_last), .array_ready(a_ready),
        .trigger_idle(t_idle), .acquisition_done(done), .actual_interval_units(units),
        .voltage_average(v_avg), .current_average(c_avg));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // the acquisitions below take about 41k cycles; a hang stops the run at 90k
    initial begin
        #900000;
        err_total++;
        report_and_stop();
    end
    task automatic start();
        @(negedge ref_clk) init_req = 1'b1;
        @(negedge ref_clk) init_req = 0;
    endtask
    task automatic fire();
        @(negedge ref_clk);
        trig_word = v_smp;
        bus_trg = (src == SRC_BUS);
        tran_trg = (src == SRC_TRANSIENT);
        pin_trg = (src == SRC_PIN);
        @(negedge ref_clk);
        {bus_trg, tran_trg, pin_trg} = 3'h0;
    endtask
    task automatic wait_done();
        int k;
        k = 0;
        while (done !== 1'b1 && k < 20000) begin
            @(negedge ref_clk);
            k++;
        end
        `CHECK("capture done", 1'b1, done)
        `CHECK("idle after capture", 1'b1, t_idle)
    endtask
    task automatic request(int req);
        @(negedge ref_clk);
        fv_req = (req == 1);
        fc_req = (req == 2);
        @(negedge ref_clk);
        {fv_req, fc_req} = 2'b00;
    endtask
    // host side with random stalls on the ready line
    task automatic collect();
        int k;
        got.delete();
        k = 0;
        while (got.size() < count && k < 30000) begin
            a_ready = 1'($urandom_range(1, 0));
            // outputs are settled here; the coming rising edge accepts this word
            if (a_valid === 1'b1 && a_ready === 1'b1) begin
                got.push_back(a_data);
                `CHECK("last flag", 1'(got.size() == count), a_last)
            end
            @(negedge ref_clk);
            k++;
        end
        a_ready = 1'b0;
        `CHECK("word count", count, 7'(got.size()))
    endtask
    task automatic check_words(logic [SAMPLE_W-1:0] base, logic [SAMPLE_W-1:0] flip);
        for (int k = 0; k < got.size(); k++) begin
            `CHECK("array word", (base + 16'(k * P)) ^ flip, got[k])
        end
    endtask
    function automatic logic [SAMPLE_W-1:0] mean(logic hann);
        longint sw, swx, idx, w;
        sw = 0;
        swx = 0;
        for (int k = 0; k < got.size(); k++) begin
            idx = k * 64 / got.size();
            w = !hann ? 255 : (idx <= 32 ? HANN_LUT[idx] : HANN_LUT[64 - idx]);
            sw += w;
            swx += w * got[k];
        end
        return (sw == 0) ? 16'h0000 : 16'(swx / sw);
    endfunction
    initial begin
        {arst_n, dual, init_req, abort_req, bus_trg, tran_trg, pin_trg, a_ready} = 8'h00;
        {mv_req, mc_req, fv_req, fc_req} = 4'h0;
        interval = 24'h000800;
        count = 7'h04;
        offset = 8'sh00;
        win = WIN_RECTANGULAR;
        qty = QTY_VOLTAGE;
        src = SRC_BUS;
        void'($urandom(20081));
        repeat (8) @(negedge ref_clk);
        arst_n = 1'b1;
        @(negedge ref_clk);
        `CHECK("done at reset", 1'b0, done)
        fire();
        repeat (3) @(negedge ref_clk);
        `CHECK("trigger while idle", 1'b1, t_idle)
        $display("test reset done");
        foreach (ivals[i]) begin
            interval = ivals[i];
            start();
            repeat (2) @(negedge ref_clk);
            `CHECK("rounded interval", uexp[i], units)
            `CHECK("armed", 1'b0, t_idle)
            @(negedge ref_clk) abort_req = 1'b1;
            @(negedge ref_clk) abort_req = 1'b0;
            @(negedge ref_clk);
            `CHECK("idle after abort", 1'b1, t_idle)
            `CHECK("no data after abort", 1'b0, done)
        end
        $display("test interval done");
        interval = 24'h000800;
        dual = 1'b1;
        start();
        request(1);
        repeat (50) @(negedge ref_clk);
        `CHECK("held fetch", 1'b0, a_valid)
        fire();
        wait_done();
        collect();
        check_words(trig_word, 16'h0000);
        `CHECK("rect mean", mean(1'b0), v_avg)
        request(2);
        collect();
        check_words(trig_word, 16'hFFFF);
        request(1);
        collect();
        check_words(trig_word, 16'h0000);
        $display("test offset zero done");
        dual = 1'b0;
        qty = QTY_CURRENT;
        win = WIN_HANNING;
        src = SRC_TRANSIENT;
        offset = 8'sh02;
        start();
        fire();
        wait_done();
        request(2);
        collect();
        check_words(trig_word + 16'(2 * P), 16'hFFFF);
        `CHECK("hanning mean", mean(1'b1), c_avg)
        $display("test delayed hanning done");
        count = 7'h05;
        offset = -8'sd3;
        src = SRC_PIN;
        win = WIN_RECTANGULAR;
        dual = 1'b1;
        start();
        fire();
        repeat (4 * P) @(negedge ref_clk);
        fire();
        wait_done();
        request(1);
        collect();
        check_words(got[0], 16'h0000);
        `CHECK("pre split", 1'b1, 1'(16'(got[3] - trig_word - 16'h0001) < 16'(P)))
        $display("test pre-trigger done");
        count = 7'h04;
        offset = 8'sh00;
        src = trig_src_t'(2'h3);
        for (int q = 0; q < 2; q++) begin
            fl = (q == 0) ? 16'h0000 : 16'hFFFF;
            @(negedge ref_clk);
            {mv_req, mc_req} = (q == 0) ? 2'b10 : 2'b01;
            @(negedge ref_clk);
            {mv_req, mc_req} = 2'b00;
            // the self trigger stores at the next rising edge, which sees this word
            trig_word = v_smp;
            collect();
            check_words(trig_word, fl);
        end
        @(negedge ref_clk);
        `CHECK("idle after measure", 1'b1, t_idle)
        $display("test measure done");
        report_and_stop();
    end
endmodule
`default_nettype wire
